/* File: feps_backend.sv */
// back-end model: transmit burst pin and transmit word clock
`timescale 1ns/1ps
`default_nettype none
module feps_backend (
  input wire logic ref_clk,
  output logic transmit_burst_pin,
  output logic transmit_word_clock
);
  // ****************************************
  // burst and word clock
  // ****************************************
  // the bench parks both lines at time zero, before reset is released
  task automatic park();
    transmit_burst_pin <= 1'b0;
    transmit_word_clock <= 1'b0;
  endtask : park
  // four reference cycles a word; the clock stands low between calls
  task automatic ticks(input int n);
    repeat (n) begin
      transmit_word_clock <= 1'b1;
      repeat (2) @(posedge ref_clk);
      transmit_word_clock <= 1'b0;
      repeat (2) @(posedge ref_clk);
    end
  endtask : ticks
  // the caller runs ticks after the fall so the filter can drain
  task automatic tx_burst(input int len);
    transmit_burst_pin <= 1'b1;
    ticks(len);
    transmit_burst_pin <= 1'b0;
  endtask : tx_burst
endmodule : feps_backend
`default_nettype wire

/* File: feps_pkg.sv */
// constants, field layouts and carrier types of the front-end power sequencer
package feps_pkg;

  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [6:0] REG_MASK_PIN_LOW = 7'h01;
  localparam logic [6:0] REG_MASK_PIN_HIGH = 7'h02;
  localparam logic [6:0] REG_HDX_CTRL = 7'h03;

  localparam logic [7:0] MASK_PIN_LOW_RST = 8'h00;
  localparam logic [7:0] MASK_PIN_HIGH_RST = 8'h7f;
  localparam logic [7:0] HDX_CTRL_RST = 8'hff;

  // ************************************************************
  // block bit positions in both masks
  // ************************************************************
  localparam int BLK_PLL = 7;
  localparam int BLK_TX_CONV = 6;
  localparam int BLK_TX_DIGITAL = 5;
  localparam int BLK_REF = 4;
  localparam int BLK_CONV_CM = 3;
  localparam int BLK_ADC = 2;
  localparam int BLK_GAIN_BIAS = 1;
  localparam int BLK_RX_GAIN = 0;

  // ************************************************************
  // half-duplex control fields
  // ************************************************************
  localparam int HDX_DELAY_MSB = 7;
  localparam int HDX_DELAY_LSB = 3;
  localparam int HDX_RX_VIA_TX = 2;
  localparam int HDX_EN_TX_PD = 1;
  localparam int HDX_EN_RX_PD = 0;

  localparam logic [5:0] FLUSH_WORD_CYCLES = 6'h21;

  // ************************************************************
  // serial port frame
  // ************************************************************
  localparam logic [4:0] SPI_CMD_LAST = 5'h07;
  localparam logic [4:0] SPI_FRAME_LAST = 5'h0f;
  localparam logic [4:0] SPI_FRAME_BITS = 5'h10;
  localparam logic [1:0] STRAP_WAIT = 2'h3;

  // ************************************************************
  // timing (all met: three cycles pin to output, four through the burst sequencer)
  // ************************************************************
  localparam int CLK_PERIOD_NS = 25;
  localparam int FAST_PD_NS = 100;
  localparam int TX_PU_NS = 500;
  localparam int RX_PU_NS = 2000;
  localparam int FAST_PD_CYC = FAST_PD_NS / CLK_PERIOD_NS;
  localparam int TX_PU_CYC = TX_PU_NS / CLK_PERIOD_NS;
  localparam int RX_PU_CYC = RX_PU_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    TX_ON = 2'b00,
    TX_DRAIN = 2'b01,
    TX_OFF = 2'b10
  } feps_tx_state_t;

  typedef struct packed {
    logic [7:0] block_pd;
    logic line_amp_pd;
    logic filter_flush;
    logic filter_disable;
  } feps_pwr_t;

endpackage : feps_pkg

/* File: feps_sequencer.sv */
// power-state controller: mask selection, burst sequencing and serial register port
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - power-select low: power down every block set in the pin-low mask
// - power-select high: power down every block set in the pin-high mask
// - power-select change acts at once, only synchroniser delay, no sequencing
// - reset: pin-low mask all zero, pin-high mask all down except the pll
// - fast control touches only tx converter/amp, tx digital, adc, rx gain
// - mask switching meets 100 ns power-down and 0.5 or 2 us power-up
// - full duplex silence low: amp down, filter disabled, used converter stays on
// - half-duplex control register only acts in half-duplex mode
// - half-duplex burst mode keeps converter on, powers amplifier down
// - burst pin fall starts a delay, then tx power-down within 100 ns
// - delay field bits 7:3, 0 to 31 word clocks, reset 31
// - filter flushed with midscale for 33 word clocks before power-down
// - burst pin rise powers tx up at once, within 0.5 us
// - bit 2 picks burst pin or receive pin to control rx power
// - burst pin fall powers rx up, rise powers rx down
// - receive pin rise powers rx up, fall powers rx down
// - bit 1 clear disables fast tx power-down, bit 0 clear fast rx
// - strap low selects half duplex, high selects full duplex
module feps_sequencer #(
  parameter logic [5:0] FLUSH_WORDS = feps_pkg::FLUSH_WORD_CYCLES,
  parameter logic [1:0] STRAP_SETTLE = feps_pkg::STRAP_WAIT
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic power_select_pin,
  input wire logic transmit_burst_pin,
  input wire logic receive_burst_pin,
  input wire logic transmit_silence_pin,
  input wire logic mode_strap_pin,
  input wire logic converter_outputs_used,
  input wire logic transmit_word_clock,
  input wire logic spi_clk,
  input wire logic spi_sel_n,
  input wire logic sdio_in,
  output logic sdio_out,
  output logic sdio_oe_n,
  output feps_pkg::feps_pwr_t pwr
);
  import feps_pkg::*;

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic ps_s1;
    logic ps_s2;
    logic txb_s1;
    logic txb_s2;
    logic txb_d;
    logic rxb_s1;
    logic rxb_s2;
    logic sil_s1;
    logic sil_s2;
    logic mode_s1;
    logic mode_s2;
    logic used_s1;
    logic used_s2;
    logic wclk_s1;
    logic wclk_s2;
    logic wclk_d;
    logic sclk_s1;
    logic sclk_s2;
    logic sclk_d;
    logic sen_s1;
    logic sen_s2;
    logic sdi_s1;
    logic sdi_s2;
    logic [1:0] strap_cnt;
    logic strap_done;
    logic half_duplex;
    logic [7:0] mask_lo;
    logic [7:0] mask_hi;
    logic [7:0] hdx;
    logic [4:0] spi_cnt;
    logic [15:0] spi_sh;
    logic [7:0] sdo_sh;
    logic spi_rd;
    logic sdo;
    logic sdo_oe_n;
    feps_tx_state_t tx_st;
    logic [5:0] word_cnt;
    feps_pwr_t pwr;
  } feps_state_t;

  localparam feps_state_t ST_RESET = '{
    sen_s1: 1'b1,
    sen_s2: 1'b1,
    // silence is active low; flops reset low would mute the amplifier after reset
    sil_s1: 1'b1,
    sil_s2: 1'b1,
    mask_lo: MASK_PIN_LOW_RST,
    mask_hi: MASK_PIN_HIGH_RST,
    hdx: HDX_CTRL_RST,
    sdo_oe_n: 1'b1,
    tx_st: TX_ON,
    default: '0
  };

  feps_state_t st_r;
  feps_state_t st_nxt;

  function automatic logic [7:0] read_reg(input feps_state_t s, input logic [6:0] a);
    logic [7:0] d;
    // unmapped addresses read back as zero
    d = 8'h00;
    if (a == REG_MASK_PIN_LOW) begin
      d = s.mask_lo;
    end else if (a == REG_MASK_PIN_HIGH) begin
      d = s.mask_hi;
    end else if (a == REG_HDX_CTRL) begin
      d = s.hdx;
    end
    return d;
  endfunction : read_reg

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    logic txb_rise;
    logic txb_fall;
    logic wclk_rise;
    logic sclk_rise;
    logic sclk_fall;
    logic [15:0] sh_new;
    logic [4:0] delay;
    logic hd_tx;
    logic hd_rx;
    logic tx_amp_off;
    logic tx_dig_off;
    logic rx_off;
    logic quiet;
    logic [7:0] sel_mask;
    logic [7:0] pd;
    st_nxt = st_r;
    txb_rise = 1'b0;
    txb_fall = 1'b0;
    wclk_rise = 1'b0;
    sclk_rise = 1'b0;
    sclk_fall = 1'b0;
    sh_new = 16'h0000;
    delay = 5'h00;
    hd_tx = 1'b0;
    hd_rx = 1'b0;
    tx_amp_off = 1'b0;
    tx_dig_off = 1'b0;
    rx_off = 1'b0;
    quiet = 1'b0;
    sel_mask = 8'h00;
    pd = 8'h00;

    // ************************************************************
    // input synchronisers
    // ************************************************************
    // pins from outside pass two flops before use
    st_nxt.ps_s1 = power_select_pin;
    st_nxt.ps_s2 = st_r.ps_s1;
    st_nxt.txb_s1 = transmit_burst_pin;
    st_nxt.txb_s2 = st_r.txb_s1;
    st_nxt.txb_d = st_r.txb_s2;
    st_nxt.rxb_s1 = receive_burst_pin;
    st_nxt.rxb_s2 = st_r.rxb_s1;
    st_nxt.sil_s1 = transmit_silence_pin;
    st_nxt.sil_s2 = st_r.sil_s1;
    st_nxt.mode_s1 = mode_strap_pin;
    st_nxt.mode_s2 = st_r.mode_s1;
    st_nxt.used_s1 = converter_outputs_used;
    st_nxt.used_s2 = st_r.used_s1;
    st_nxt.wclk_s1 = transmit_word_clock;
    st_nxt.wclk_s2 = st_r.wclk_s1;
    st_nxt.wclk_d = st_r.wclk_s2;
    st_nxt.sclk_s1 = spi_clk;
    st_nxt.sclk_s2 = st_r.sclk_s1;
    st_nxt.sclk_d = st_r.sclk_s2;
    st_nxt.sen_s1 = spi_sel_n;
    st_nxt.sen_s2 = st_r.sen_s1;
    st_nxt.sdi_s1 = sdio_in;
    st_nxt.sdi_s2 = st_r.sdi_s1;

    txb_rise = st_r.txb_s2 & ~st_r.txb_d;
    txb_fall = ~st_r.txb_s2 & st_r.txb_d;
    // the word clock is sampled, so each of its phases must span two reference cycles
    wclk_rise = st_r.wclk_s2 & ~st_r.wclk_d;
    sclk_rise = st_r.sclk_s2 & ~st_r.sclk_d;
    sclk_fall = ~st_r.sclk_s2 & st_r.sclk_d;

    // ************************************************************
    // duplex strap, caught once the synchroniser has settled
    // ************************************************************
    // read once only: a strap that moves later must not swap the interface mid-burst
    if (!st_r.strap_done) begin
      if (st_r.strap_cnt == STRAP_SETTLE) begin
        st_nxt.half_duplex = ~st_r.mode_s2;
        st_nxt.strap_done = 1'b1;
      end else begin
        st_nxt.strap_cnt = st_r.strap_cnt + 2'h1;
      end
    end

    // ************************************************************
    // serial register port: r/w bit, 7 address bits, 8 data bits
    // ************************************************************
    if (st_r.sen_s2) begin
      st_nxt.spi_cnt = 5'h00;
      st_nxt.spi_rd = 1'b0;
      st_nxt.sdo_oe_n = 1'b1;
    end else begin
      // clocks past the sixteenth bit are ignored until select goes high
      if (sclk_rise && st_r.spi_cnt < SPI_FRAME_BITS) begin
        sh_new = {st_r.spi_sh[14:0], st_r.sdi_s2};
        st_nxt.spi_sh = sh_new;
        st_nxt.spi_cnt = st_r.spi_cnt + 5'h01;
        if (st_r.spi_cnt == SPI_CMD_LAST && sh_new[7]) begin
          st_nxt.spi_rd = 1'b1;
          st_nxt.sdo_sh = read_reg(st_r, sh_new[6:0]);
        end
        if (st_r.spi_cnt == SPI_FRAME_LAST && !sh_new[15]) begin
          if (sh_new[14:8] == REG_MASK_PIN_LOW) begin
            st_nxt.mask_lo = sh_new[7:0];
          end else if (sh_new[14:8] == REG_MASK_PIN_HIGH) begin
            st_nxt.mask_hi = sh_new[7:0];
          end else if (sh_new[14:8] == REG_HDX_CTRL) begin
            st_nxt.hdx = sh_new[7:0];
          end
        end
      end
      // read data leaves on falling edges so the master samples it on rising ones
      if (sclk_fall && st_r.spi_rd) begin
        if (st_r.spi_cnt == SPI_FRAME_BITS) begin
          st_nxt.sdo_oe_n = 1'b1;
          st_nxt.spi_rd = 1'b0;
        end else begin
          st_nxt.sdo = st_r.sdo_sh[7];
          st_nxt.sdo_sh = {st_r.sdo_sh[6:0], 1'b0};
          st_nxt.sdo_oe_n = 1'b0;
        end
      end
    end

    // ************************************************************
    // transmit burst sequencing
    // ************************************************************
    delay = st_r.hdx[HDX_DELAY_MSB:HDX_DELAY_LSB];
    hd_tx = st_r.half_duplex & st_r.hdx[HDX_EN_TX_PD];
    hd_rx = st_r.half_duplex & st_r.hdx[HDX_EN_RX_PD];

    case (st_r.tx_st)
      TX_ON: begin
        if (txb_fall) begin
          st_nxt.tx_st = TX_DRAIN;
          st_nxt.word_cnt = 6'h00;
        end
      end
      TX_DRAIN: begin
        if (txb_rise) begin
          st_nxt.tx_st = TX_ON;
        end else begin
          if (wclk_rise && st_r.word_cnt < FLUSH_WORDS) begin
            st_nxt.word_cnt = st_r.word_cnt + 6'h01;
          end
          // the filter is shut only after a full flush; a stopped word clock
          // leaves the sequence waiting here rather than cutting it short
          if (st_r.word_cnt >= FLUSH_WORDS) begin
            st_nxt.tx_st = TX_OFF;
          end
        end
      end
      TX_OFF: begin
        // the converter never left power, so a new burst needs no warm-up here
        if (txb_rise) begin
          st_nxt.tx_st = TX_ON;
        end
      end
      default: begin
        // unused encoding: fall back to powered-on
        st_nxt.tx_st = TX_ON;
      end
    endcase
    if (!hd_tx) begin
      st_nxt.tx_st = TX_ON;
    end

    tx_amp_off = hd_tx & ((st_r.tx_st == TX_OFF) ||
      (st_r.tx_st == TX_DRAIN && st_r.word_cnt >= {1'b0, delay}));
    tx_dig_off = hd_tx & (st_r.tx_st == TX_OFF);

    // ************************************************************
    // receive path fast control
    // ************************************************************
    // following the chosen pin's level gives the same result as acting on its edges
    if (st_r.hdx[HDX_RX_VIA_TX]) begin
      rx_off = hd_rx & st_r.txb_s2;
    end else begin
      rx_off = hd_rx & ~st_r.rxb_s2;
    end

    // silence belongs to full duplex; in half duplex the burst pin owns the transmit path
    quiet = ~st_r.half_duplex & ~st_r.sil_s2;

    // ************************************************************
    // output composition
    // ************************************************************
    sel_mask = st_r.ps_s2 ? st_r.mask_hi : st_r.mask_lo;
    pd = sel_mask;
    // converter stays on under burst control; only the amplifier follows it
    pd[BLK_TX_CONV] = sel_mask[BLK_TX_CONV] | (quiet & ~st_r.used_s2);
    pd[BLK_TX_DIGITAL] = sel_mask[BLK_TX_DIGITAL] | tx_dig_off;
    pd[BLK_ADC] = sel_mask[BLK_ADC] | rx_off;
    pd[BLK_RX_GAIN] = sel_mask[BLK_RX_GAIN] | rx_off;
    st_nxt.pwr.block_pd = pd;
    st_nxt.pwr.line_amp_pd = sel_mask[BLK_TX_CONV] | tx_amp_off | quiet;
    st_nxt.pwr.filter_flush = hd_tx & (st_r.tx_st == TX_DRAIN) &
      (st_r.word_cnt < FLUSH_WORDS);
    st_nxt.pwr.filter_disable = sel_mask[BLK_TX_DIGITAL] | tx_dig_off | quiet;
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_r <= ST_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign sdio_out = st_r.sdo;
  assign sdio_oe_n = st_r.sdo_oe_n;
  assign pwr = st_r.pwr;

endmodule : feps_sequencer

`default_nettype wire

/* File: feps_sequencer_chk.sv */
// port checker for the front-end power sequencer
`timescale 1ns/1ps
`default_nettype none
module feps_sequencer_chk (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic power_select_pin,
  input wire logic transmit_burst_pin,
  input wire logic transmit_silence_pin,
  input wire logic mode_strap_pin,
  input wire logic spi_sel_n,
  input wire feps_pkg::feps_pwr_t pwr
);
  import feps_pkg::*;
  // ****************************************
  // helpers
  // ****************************************
  // register writes move the masks, so slow bits are judged only once the port is quiet
  logic [3:0] quiet_r;
  logic [3:0] quiet_nxt;
  logic [3:0] slow;
  assign slow = {pwr.block_pd[7], pwr.block_pd[4], pwr.block_pd[3], pwr.block_pd[1]};
  always_comb quiet_nxt = (rst || !spi_sel_n) ? 4'h0 : quiet_r + {3'h0, quiet_r != 4'hf};
  always_ff @(posedge ref_clk) quiet_r <= quiet_nxt;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ****************************************
  // assertions
  // ****************************************
  AST_RESET_MASK_LOW:
  assert property ($fell(rst) ##0 !power_select_pin [*5] |-> pwr.block_pd == 8'h00)
    else $error("block power-down not all on after reset");
  AST_RESET_MASK_HIGH:
  assert property ($fell(rst) ##0 power_select_pin [*5] |-> pwr.block_pd == 8'h7f)
    else $error("block power-down not all off but pll after reset");
  AST_SLOW_BITS:
  assert property ((quiet_r == 4'hf) && $changed(slow)
    |-> $past(power_select_pin, 2) != $past(power_select_pin, 6))
    else $error("slow block changed without a power-select change");
  AST_TX_RISE_ON:
  assert property ($rose(transmit_burst_pin) ##0 (transmit_burst_pin && transmit_silence_pin) [*6]
    |-> !pwr.line_amp_pd && !pwr.filter_flush && !pwr.filter_disable)
    else $error("transmit path not on after burst rise");
  AST_FLUSH_CAUSE:
  assert property ($rose(pwr.filter_flush)
    |-> !$past(transmit_burst_pin, 4) || !$past(transmit_burst_pin, 5))
    else $error("flush started without a burst fall");
  AST_FLUSH_END:
  assert property ($fell(pwr.filter_flush) && !transmit_burst_pin
    |-> ##[0:2] (pwr.filter_disable && pwr.block_pd[5]))
    else $error("filter not powered down after flush");
  AST_DISABLE_CAUSE:
  assert property ($rose(pwr.filter_disable)
    |-> !$past(transmit_burst_pin, 3) || !$past(transmit_silence_pin, 3))
    else $error("filter disabled without cause");
  AST_SILENCE_FD:
  assert property ((mode_strap_pin && !transmit_silence_pin) [*6]
    |-> pwr.line_amp_pd && pwr.filter_disable)
    else $error("silence did not stop amplifier and filter");
  cover property ($rose(pwr.line_amp_pd));
  cover property ($fell(pwr.filter_flush));
  cover property ($rose(pwr.filter_disable) && mode_strap_pin);
endmodule : feps_sequencer_chk
`default_nettype wire

/* File: test_front_end_power_sequencer.sv */
// testbench for the front-end power sequencer
`timescale 1ns/1ps
`default_nettype none
module test_front_end_power_sequencer;
  import feps_pkg::*;
  logic ref_clk, rst, power_select_pin, receive_burst_pin, transmit_silence_pin;
  logic mode_strap_pin, converter_outputs_used, spi_clk, spi_sel_n, sdio_drv;
  logic sdio_out, sdio_oe_n, transmit_burst_pin, transmit_word_clock;
  wire logic sdio_in;
  feps_pwr_t pwr;
  int err_count = 0;
  int comparisons = 0;
  // the device owns the data wire while its enable is low
  assign sdio_in = sdio_oe_n ? sdio_drv : sdio_out;
  feps_sequencer feps_sequencer_inst (.ref_clk(ref_clk), .rst(rst),
    .power_select_pin(power_select_pin), .transmit_burst_pin(transmit_burst_pin),
    .receive_burst_pin(receive_burst_pin), .transmit_silence_pin(transmit_silence_pin),
    .mode_strap_pin(mode_strap_pin), .converter_outputs_used(converter_outputs_used),
    .transmit_word_clock(transmit_word_clock), .spi_clk(spi_clk), .spi_sel_n(spi_sel_n),
    .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n), .pwr(pwr));
  feps_backend feps_backend_inst (.ref_clk(ref_clk), .transmit_burst_pin(transmit_burst_pin),
    .transmit_word_clock(transmit_word_clock));
  // ****************************************
  // shared tasks
  // ****************************************
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cyc
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : conclude
  task automatic do_reset(input logic strap);
    rst <= 1'b1;
    mode_strap_pin <= strap;
    cyc(5);
    rst <= 1'b0;
    cyc(12);
  endtask : do_reset
  task automatic park_pins();
    power_select_pin <= 1'b0;
    receive_burst_pin <= 1'b1;
    transmit_silence_pin <= 1'b1;
    converter_outputs_used <= 1'b0;
    spi_clk <= 1'b0;
    spi_sel_n <= 1'b1;
    sdio_drv <= 1'b0;
  endtask : park_pins
  // serial clock phases of five cycles keep above the four-cycle minimum
  task automatic spi(input logic [15:0] frame, output logic [7:0] rd);
    spi_sel_n <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      sdio_drv <= frame[i];
      cyc(5);
      if (i < 8) rd[i] = sdio_in;
      spi_clk <= 1'b1;
      cyc(5);
      spi_clk <= 1'b0;
    end
    cyc(5);
    spi_sel_n <= 1'b1;
    cyc(8);
  endtask : spi
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] unused;
    spi({1'b0, a, d}, unused);
  endtask : wr
  task automatic rd_check(input string what, input logic [6:0] a, input logic [7:0] exp);
    logic [7:0] v;
    spi({1'b1, a, 8'h00}, v);
    check(what, v, exp);
  endtask : rd_check
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_regs();
    rd_check("mask low reset", REG_MASK_PIN_LOW, 8'h00);
    rd_check("mask high reset", REG_MASK_PIN_HIGH, 8'h7f);
    rd_check("hdx reset", REG_HDX_CTRL, 8'hff);
    rd_check("unmapped", 7'h05, 8'h00);
    check("pd reset", pwr.block_pd, 8'h00);
    $display("t_regs done");
  endtask : t_regs
  task automatic t_masks();
    wr(REG_MASK_PIN_LOW, 8'ha5);
    wr(REG_MASK_PIN_HIGH, 8'h5a);
    rd_check("mask low", REG_MASK_PIN_LOW, 8'ha5);
    cyc(10);
    check("pd sel low", pwr.block_pd, 8'ha5);
    power_select_pin <= 1'b1;
    cyc(4);
    check("pd sel high", pwr.block_pd, 8'h5a);
    power_select_pin <= 1'b0;
    cyc(4);
    check("pd back low", pwr.block_pd, 8'ha5);
    $display("t_masks done");
  endtask : t_masks
  task automatic t_burst();
    int n;
    logic wprev;
    n = 0;
    wprev = 1'b0;
    wr(REG_MASK_PIN_LOW, 8'h00);
    wr(REG_HDX_CTRL, 8'h27);
    fork
      feps_backend_inst.tx_burst(4);
      begin
        cyc(8);
        check("rx off in burst", pwr.block_pd, 8'h05);
      end
    join
    fork
      feps_backend_inst.ticks(40);
      repeat (100) begin
        @(posedge ref_clk);
        if (pwr.line_amp_pd === 1'b0 && transmit_word_clock && !wprev) n++;
        wprev = transmit_word_clock;
      end
    join
    check("delay words", {7'h0, n == 4 || n == 5}, 8'h01);
    check("tx off pd", pwr.block_pd, 8'h20);
    check("tx off amp", {5'h0, pwr.line_amp_pd, pwr.filter_flush, pwr.filter_disable},
      8'h05);
    wr(REG_HDX_CTRL, 8'ha7);
    feps_backend_inst.tx_burst(2);
    feps_backend_inst.ticks(6);
    check("drain flush", {6'h0, pwr.filter_flush, pwr.line_amp_pd}, 8'h02);
    feps_backend_inst.tx_burst(30);
    check("cancel amp", {7'h0, pwr.line_amp_pd}, 8'h00);
    feps_backend_inst.ticks(40);
    $display("t_burst done");
  endtask : t_burst
  task automatic t_rx_pin();
    wr(REG_HDX_CTRL, 8'h23);
    receive_burst_pin <= 1'b0;
    cyc(4);
    check("rx pin low", pwr.block_pd & 8'h05, 8'h05);
    receive_burst_pin <= 1'b1;
    cyc(4);
    check("rx pin high", pwr.block_pd & 8'h05, 8'h00);
    wr(REG_HDX_CTRL, 8'h20);
    receive_burst_pin <= 1'b0;
    feps_backend_inst.tx_burst(3);
    feps_backend_inst.ticks(40);
    check("fast off disabled", pwr.block_pd, 8'h00);
    check("amp kept", {6'h0, pwr.line_amp_pd, pwr.filter_disable}, 8'h00);
    $display("t_rx_pin done");
  endtask : t_rx_pin
  task automatic t_full_duplex();
    power_select_pin <= 1'b1;
    do_reset(1'b1);
    wr(REG_MASK_PIN_LOW, 8'h60);
    wr(REG_MASK_PIN_HIGH, 8'h05);
    check("fd sel high", pwr.block_pd, 8'h05);
    feps_backend_inst.tx_burst(3);
    feps_backend_inst.ticks(40);
    check("fd burst ignored", {5'h0, pwr.line_amp_pd, pwr.filter_flush, pwr.filter_disable},
      8'h00);
    transmit_silence_pin <= 1'b0;
    cyc(4);
    check("silence pd", pwr.block_pd, 8'h45);
    converter_outputs_used <= 1'b1;
    cyc(4);
    check("silence used", pwr.block_pd, 8'h05);
    transmit_silence_pin <= 1'b1;
    power_select_pin <= 1'b0;
    cyc(4);
    check("fd sel low", pwr.block_pd, 8'h60);
    $display("t_full_duplex done");
  endtask : t_full_duplex
  initial begin
    park_pins();
    feps_backend_inst.park();
    do_reset(1'b0);
    t_regs();
    t_masks();
    t_burst();
    t_rx_pin();
    t_full_duplex();
    conclude();
  end
  initial begin
    cyc(20000);
    err_count++;
    conclude();
  end
endmodule : test_front_end_power_sequencer
bind feps_sequencer feps_sequencer_chk feps_sequencer_chk_inst (.ref_clk(ref_clk), .rst(rst),
  .power_select_pin(power_select_pin), .transmit_burst_pin(transmit_burst_pin),
  .transmit_silence_pin(transmit_silence_pin), .mode_strap_pin(mode_strap_pin),
  .spi_sel_n(spi_sel_n), .pwr(pwr));
`default_nettype wire
